// File: verilog/polarity_regs_pkg.sv
// Package with register map, field positions and reset values for the polarity and reset slice.
package polarity_regs_pkg;
   localparam logic [15:0] GAIN_POLARITY_ADDR = 16'h01d5;
   localparam logic [15:0] CODING_CTRL_ADDR = 16'h0000;
   localparam int TX_INVERT_BIT = 1;
   localparam int RX_INVERT_BIT = 0;
   localparam int CODING_RESET_BIT = 15;
   localparam logic [15:0] GAIN_POLARITY_RESET = 16'hf500;
   localparam logic [15:0] CODING_CTRL_RESET = 16'h0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic ext;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_type;
endpackage

// File: verilog/serdes_polarity_coding_sublayer_reset_regs.sv
// Polarity controls and self-clearing coding-sublayer reset register slice.
`timescale 1ns/1ps
`default_nettype none
module serdes_polarity_coding_sublayer_reset_regs
   import polarity_regs_pkg::*;
#(
   parameter int LANE_WIDTH = 10
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire reg_req_type req_in,
   output logic [15:0] rdata_out,
   output logic rvalid_out,
   input wire logic [LANE_WIDTH-1:0] tx_data_in,
   output logic [LANE_WIDTH-1:0] tx_line_out,
   input wire logic [LANE_WIDTH-1:0] rx_line_in,
   output logic [LANE_WIDTH-1:0] rx_data_out,
   output logic coding_sublayer_reset_out,
   output logic soft_reset_out
);

   logic [15:0] gain_and_polarity;
   logic coding_sublayer_reset;
   logic soft_reset;

   function automatic logic hit(input reg_req_type r, input logic ext, input logic [15:0] a);
      hit = (r.ext == ext) && (r.addr == a);
   endfunction

   function automatic logic [LANE_WIDTH-1:0] lane_invert(input logic [LANE_WIDTH-1:0] d,
                                                         input logic inv);
      lane_invert = d ^ {LANE_WIDTH{inv}};
   endfunction

   logic rd_gain;
   logic rd_coding;
   logic wr_direct_zero;
   assign rd_gain = req_in.rd && hit(req_in, 1'b0, GAIN_POLARITY_ADDR);
   assign rd_coding = req_in.rd && hit(req_in, 1'b1, CODING_CTRL_ADDR);
   // A direct write to address 0 belongs to the basic control register, not to this slice.
   assign wr_direct_zero = req_in.wr && hit(req_in, 1'b0, CODING_CTRL_ADDR);

   logic wr_gain;
   logic wr_coding;
   assign wr_gain = req_in.wr && hit(req_in, 1'b0, GAIN_POLARITY_ADDR);
   // Only the extended path reaches the control register; direct address 0 is not ours.
   assign wr_coding = req_in.wr && hit(req_in, 1'b1, CODING_CTRL_ADDR);

   always_ff @(posedge core_clk_in) begin
      if (reset_in || soft_reset) begin
         gain_and_polarity <= GAIN_POLARITY_RESET;
      end else if (wr_gain) begin
         gain_and_polarity <= req_in.wdata;
      end
   end

   // The reset bit is a one-cycle pulse; it clears itself on the next edge.
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         coding_sublayer_reset <= 1'b0;
      end else begin
         coding_sublayer_reset <= wr_coding && req_in.wdata[CODING_RESET_BIT];
      end
   end

   // Soft reset follows one cycle after the sublayer reset, as a basic control reset would.
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= coding_sublayer_reset;
      end
   end

   logic [15:0] next_rdata;
   always_comb begin
      if (rd_gain) begin
         next_rdata = gain_and_polarity;
      end else if (rd_coding) begin
         // Only the reset bit is live; the reserved field is hard zero.
         next_rdata = {coding_sublayer_reset, 15'h0000};
      end else begin
         next_rdata = 16'h0000;
      end
   end

   // Read data holds until the next read, so software may pick it up late.
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rdata_out <= 16'h0000;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= req_in.rd;
         if (req_in.rd) begin
            rdata_out <= next_rdata;
         end
      end
   end

   // Registered line data keeps the complement glitch free; costs one cycle of latency.
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         tx_line_out <= '0;
         rx_data_out <= '0;
      end else begin
         tx_line_out <= lane_invert(tx_data_in, gain_and_polarity[TX_INVERT_BIT]);
         rx_data_out <= lane_invert(rx_line_in, gain_and_polarity[RX_INVERT_BIT]);
      end
   end

   assign coding_sublayer_reset_out = coding_sublayer_reset;
   assign soft_reset_out = soft_reset;

   AST_TX_INV: assert property (@(posedge core_clk_in) disable iff (reset_in)
      ##1 tx_line_out == ($past(tx_data_in) ^ {LANE_WIDTH{$past(gain_and_polarity[TX_INVERT_BIT])}}))
      else $error("tx line not complemented per control bit");
   AST_RX_INV: assert property (@(posedge core_clk_in) disable iff (reset_in)
      ##1 rx_data_out == ($past(rx_line_in) ^ {LANE_WIDTH{$past(gain_and_polarity[RX_INVERT_BIT])}}))
      else $error("rx data not complemented per control bit");
   AST_RESET_PULSE: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_coding && req_in.wdata[CODING_RESET_BIT]) |=> coding_sublayer_reset ##1 !coding_sublayer_reset)
      else $error("sublayer reset did not pulse and self clear");
   AST_SOFT_FOLLOWS: assert property (@(posedge core_clk_in) disable iff (reset_in)
      coding_sublayer_reset |=> soft_reset ##1 (gain_and_polarity == GAIN_POLARITY_RESET))
      else $error("soft reset did not follow sublayer reset");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (req_in.rd && hit(req_in, 1'b1, CODING_CTRL_ADDR)) |=> (rdata_out[14:0] == 15'h0000))
      else $error("reserved bits read nonzero");
   AST_DIRECT_NO_RESET: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (req_in.wr && !req_in.ext && !($past(req_in.wr) && $past(req_in.ext))) |=> !coding_sublayer_reset)
      else $error("direct write caused sublayer reset");
   AST_REG_HOLD: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (!wr_gain && !soft_reset) |=> $stable(gain_and_polarity))
      else $error("gain register changed without write");
   AST_WRITE_LAND: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_gain && !soft_reset) |=> (gain_and_polarity == $past(req_in.wdata)))
      else $error("gain write not stored");

   // Reset values and line behaviour for each state of the polarity bits.
   AST_GAIN_RESET_VAL: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $past(reset_in)
      |-> (gain_and_polarity == GAIN_POLARITY_RESET))
      else $error("gain register not at reset value after reset");
   AST_TX_NORMAL: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !gain_and_polarity[TX_INVERT_BIT]
      |=> (tx_line_out == $past(tx_data_in)))
      else $error("tx line altered with polarity normal");
   AST_TX_INVERT_SET: assert property (@(posedge core_clk_in) disable iff (reset_in)
      gain_and_polarity[TX_INVERT_BIT]
      |=> (tx_line_out == ~$past(tx_data_in)))
      else $error("tx line not inverted with invert bit set");
   AST_RX_NORMAL: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !gain_and_polarity[RX_INVERT_BIT]
      |=> (rx_data_out == $past(rx_line_in)))
      else $error("rx data altered with polarity normal");
   AST_RX_INVERT_SET: assert property (@(posedge core_clk_in) disable iff (reset_in)
      gain_and_polarity[RX_INVERT_BIT]
      |=> (rx_data_out == ~$past(rx_line_in)))
      else $error("rx data not inverted with invert bit set");

   // The reset bit and the soft reset must never appear on their own.
   AST_CS_RESET_QUIET: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !(wr_coding && req_in.wdata[CODING_RESET_BIT])
      |=> !coding_sublayer_reset)
      else $error("sublayer reset raised without a request");
   AST_CTRL_READ_BIT15: assert property (@(posedge core_clk_in) disable iff (reset_in)
      rd_coding
      |=> (rdata_out[CODING_RESET_BIT] == $past(coding_sublayer_reset)))
      else $error("control read does not show the reset bit");
   AST_SOFT_ONLY_AFTER: assert property (@(posedge core_clk_in) disable iff (reset_in)
      soft_reset
      |-> $past(coding_sublayer_reset))
      else $error("soft reset without a sublayer reset before it");
   AST_SOFT_PULSE: assert property (@(posedge core_clk_in) disable iff (reset_in)
      soft_reset
      |=> !soft_reset)
      else $error("soft reset longer than one cycle");
   AST_POLARITY_CLEAR_AFTER_SOFT: assert property (@(posedge core_clk_in) disable iff (reset_in)
      soft_reset
      |=> (!gain_and_polarity[TX_INVERT_BIT] && !gain_and_polarity[RX_INVERT_BIT]))
      else $error("polarity bits not cleared by soft reset");
   AST_RESERVED_WRITE_IGNORED: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_coding && !req_in.wdata[CODING_RESET_BIT])
      |=> !coding_sublayer_reset)
      else $error("reserved write had an effect");

   // Direct addresses must never reach the extended control register.
   AST_DIRECT_ZERO_IGNORED: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_direct_zero
      |=> !coding_sublayer_reset)
      else $error("direct write to address zero reset the sublayer");
   AST_UNMAPPED_READ_ZERO: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (req_in.rd && !rd_gain && !rd_coding)
      |=> (rdata_out == 16'h0000))
      else $error("unmapped read returned nonzero data");
   AST_GAIN_DIRECT_ONLY: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (req_in.wr && req_in.ext && !soft_reset)
      |=> $stable(gain_and_polarity))
      else $error("extended write changed the gain register");

   COV_CTRL_READ: cover property (@(posedge core_clk_in) disable iff (reset_in)
      rd_coding);
   COV_DIRECT_ZERO: cover property (@(posedge core_clk_in) disable iff (reset_in)
      wr_direct_zero);
   COV_TX_INV: cover property (@(posedge core_clk_in) disable iff (reset_in)
      gain_and_polarity[TX_INVERT_BIT]);
   COV_RX_INV: cover property (@(posedge core_clk_in) disable iff (reset_in)
      gain_and_polarity[RX_INVERT_BIT]);
   COV_RESET_SEQ: cover property (@(posedge core_clk_in) disable iff (reset_in)
      coding_sublayer_reset ##1 soft_reset);
endmodule
`default_nettype wire

// File: test/serdes_polarity_coding_sublayer_reset_regs_bench.sv
// Self-checking bench for the polarity and coding-sublayer reset register slice.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module serdes_polarity_coding_sublayer_reset_regs_bench;
   import polarity_regs_pkg::*;
   logic core_clk_in = 0, reset_in = 1, rvalid_out, coding_sublayer_reset_out, soft_reset_out;
   reg_req_type req_in = '0;
   logic [15:0] rdata_out, got;
   logic [9:0] tx_data_in = '0, rx_line_in = '0, tx_line_out, rx_data_out;
   int fail_count = 0, samples_checked = 0;
   serdes_polarity_coding_sublayer_reset_regs #(.LANE_WIDTH(10)) i_serdes_polarity_coding_sublayer_reset_regs (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .req_in(req_in), .rdata_out(rdata_out),
      .rvalid_out(rvalid_out), .tx_data_in(tx_data_in), .tx_line_out(tx_line_out),
      .rx_line_in(rx_line_in), .rx_data_out(rx_data_out),
      .coding_sublayer_reset_out(coding_sublayer_reset_out), .soft_reset_out(soft_reset_out));
   initial begin
      forever #25 core_clk_in = ~core_clk_in;
   end
   task automatic wr(input logic ext, input logic [15:0] a, input logic [15:0] d);
      @(negedge core_clk_in);
      req_in = '{wr: 1'b1, rd: 1'b0, ext: ext, addr: a, wdata: d};
      @(negedge core_clk_in) req_in = '0;
   endtask
   task automatic rd(input logic ext, input logic [15:0] a);
      @(negedge core_clk_in);
      req_in = '{wr: 1'b0, rd: 1'b1, ext: ext, addr: a, wdata: 16'h0000};
      @(negedge core_clk_in) req_in = '0;
      `CHK("rvalid", 1'b1, rvalid_out)
      got = rdata_out;
   endtask
   task automatic t_reset_values();
      rd(1'b0, GAIN_POLARITY_ADDR); `CHK("gain reset", 16'hf500, got)
      rd(1'b1, CODING_CTRL_ADDR); `CHK("ctrl reset", 16'h0000, got)
      rd(1'b1, 16'h0055); `CHK("unmapped", 16'h0000, got)
   endtask
   task automatic t_polarity();
      for (int i = 0; i < 4; i++) begin
         wr(1'b0, GAIN_POLARITY_ADDR, 16'hf500 | 16'(i));
         tx_data_in = 10'h2a5;
         rx_line_in = 10'h1c3;
         @(negedge core_clk_in);
         `CHK("tx line", 10'h2a5 ^ {10{i[1]}}, tx_line_out)
         `CHK("rx data", 10'h1c3 ^ {10{i[0]}}, rx_data_out)
         rd(1'b0, GAIN_POLARITY_ADDR); `CHK("gain kept", 16'hf500 | 16'(i), got)
      end
   endtask
   task automatic t_coding_reset();
      wr(1'b1, CODING_CTRL_ADDR, 16'h7fff);
      `CHK("no reset pulse", 1'b0, coding_sublayer_reset_out)
      rd(1'b1, CODING_CTRL_ADDR); `CHK("reserved zero", 16'h0000, got)
      wr(1'b1, CODING_CTRL_ADDR, 16'hffff);
      `CHK("cs reset pulse", 1'b1, coding_sublayer_reset_out)
      `CHK("soft early", 1'b0, soft_reset_out)
      @(negedge core_clk_in);
      `CHK("soft reset", 1'b1, soft_reset_out)
      `CHK("cs self clear", 1'b0, coding_sublayer_reset_out)
      @(negedge core_clk_in);
      rd(1'b1, CODING_CTRL_ADDR); `CHK("ctrl cleared", 16'h0000, got)
      rd(1'b0, GAIN_POLARITY_ADDR); `CHK("gain restored", 16'hf500, got)
   endtask
   task automatic t_direct_zero();
      wr(1'b0, CODING_CTRL_ADDR, 16'h8000);
      `CHK("direct no reset", 1'b0, coding_sublayer_reset_out)
      rd(1'b0, CODING_CTRL_ADDR); `CHK("direct read", 16'h0000, got)
   endtask
   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge core_clk_in);
      reset_in = 0;
      @(negedge core_clk_in);
      t_reset_values();
      t_polarity();
      t_direct_zero();
      wr(1'b0, GAIN_POLARITY_ADDR, 16'hf503);
      t_coding_reset();
      final_report();
   end
   initial begin
      // The whole sequence needs well under 100 cycles; this leaves ample margin.
      #100000;
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
